// [verilog/asp_pkg.sv]
`default_nettype none
package asp_pkg;
  // Result word width shifted out on a read.
  localparam int unsigned WORD_W        = 16;
  localparam int unsigned CNT_W         = 5;
  // Serial clock limit and host divider.
  localparam int unsigned SCLK_MAX_KHZ  = 5000;
  localparam int unsigned MCLK_KHZ      = 100000;
  localparam int unsigned SCLK_HALF_CYC =
    (MCLK_KHZ + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ);
  localparam logic [7:0]  HALF_CNT      = 8'(SCLK_HALF_CYC);
  localparam logic [4:0]  WORD_CNT      = 5'(WORD_W);
  localparam logic        CLOCK_OUTPUT_DISABLE_RST    = 1'b0;

  typedef enum logic [1:0] {
    ASP_IDLE  = 2'b00,
    ASP_LOW   = 2'b01,
    ASP_HIGH  = 2'b11,
    ASP_DONE  = 2'b10
  } asp_state_t;
endpackage : asp_pkg
`default_nettype wire

// [verilog/asp_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface asp_if;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout_o;
  logic dout_oe;
  logic result_ready_n;
  logic master_clock_input;
  logic buffered_clock_output;
  logic buffered_clock_oe;
  logic reset_n;
  modport dev (
    input  sclk, cs_n, din, master_clock_input, reset_n,
    output dout_o, dout_oe, result_ready_n,
    output buffered_clock_output, buffered_clock_oe
  );
  modport host (
    output sclk, cs_n, din, master_clock_input, reset_n,
    input  dout_o, dout_oe, result_ready_n,
    input  buffered_clock_output, buffered_clock_oe
  );
endinterface : asp_if
`default_nettype wire

// [verilog/asp_dev.sv]
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Capture input on rising clock while selected
// - Change output after falling serial clock
// - Output bit valid at rising edge
// - Output released while chip select high
// - Master selects device for any transfer
// - Tied-low select gives three-wire operation
// - Reset input restores power-on state
// - Ready goes low on new result
// - Ready returns high after full read
// - Read shifts out result register bits
// - Disable bit: zero enables clock output
// - Clock output is inverted clock input
// - Master keeps serial clock at most 5MHz
// - Internal oscillator: clock input grounded
module asp_dev (
  // System.
  input  wire logic                       mclk,
  input  wire logic                       rst_b,
  // Pins.
  asp_if.dev                              pins,
  // Converter side.
  input  wire logic                       result_load,
  input  wire logic [asp_pkg::WORD_W-1:0] result_data,
  input  wire logic                       clock_output_disable,
  output logic      [asp_pkg::WORD_W-1:0] rx_word,
  output logic                            rx_valid
);
  import asp_pkg::*;

  logic [1:0] sclk_sync_reg;
  logic [1:0] cs_sync_reg;
  logic [1:0] din_sync_reg;
  logic [1:0] rst_sync_reg;
  logic       sclk_d_reg;
  logic [WORD_W-1:0] shift_reg;
  logic [WORD_W-1:0] rx_reg;
  logic [CNT_W-1:0]  bit_cnt_reg;
  logic       dout_reg;
  logic       ready_n_reg;
  logic       rx_valid_reg;
  logic       sel;
  logic       rise;
  logic       fall;
  logic       int_rst;

  always_ff @(posedge mclk) begin
    sclk_sync_reg <= {sclk_sync_reg[0], pins.sclk};
    cs_sync_reg   <= {cs_sync_reg[0], pins.cs_n};
    din_sync_reg  <= {din_sync_reg[0], pins.din};
    rst_sync_reg  <= {rst_sync_reg[0], pins.reset_n};
    sclk_d_reg    <= sclk_sync_reg[1];
  end

  // Either reset returns every register except the synchronizers and sclk_d_reg to its power-on state.
  assign int_rst = !rst_b || !rst_sync_reg[1];
  assign sel     = !cs_sync_reg[1];
  assign rise    = sel && sclk_sync_reg[1] && !sclk_d_reg;
  assign fall    = sel && !sclk_sync_reg[1] && sclk_d_reg;

  always_ff @(posedge mclk) begin
    if (int_rst) begin
      bit_cnt_reg <= '0;
      rx_reg      <= '0;
    end else if (rise) begin
      rx_reg <= {rx_reg[WORD_W-2:0], din_sync_reg[1]};
      if (bit_cnt_reg == WORD_CNT - 5'd1) begin
        bit_cnt_reg <= '0;
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 5'd1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (int_rst) begin
      rx_valid_reg <= 1'b0;
    end else begin
      rx_valid_reg <= rise && (bit_cnt_reg == WORD_CNT - 5'd1);
    end
  end

  // Result loads whenever bit_cnt_reg is zero and sclk_d_reg is low, which includes a read's first rise cycle.
  always_ff @(posedge mclk) begin
    if (int_rst) begin
      shift_reg <= '0;
      dout_reg  <= 1'b0;
    end else if (result_load && (bit_cnt_reg == '0) && !sclk_d_reg) begin
      shift_reg <= result_data;
      dout_reg  <= result_data[WORD_W-1];
    end else if (fall && bit_cnt_reg != '0) begin
      dout_reg  <= shift_reg[WORD_W-1];
    end else if (rise) begin
      shift_reg <= {shift_reg[WORD_W-2:0], 1'b0};
    end else if (fall) begin
      dout_reg  <= shift_reg[WORD_W-1];
    end
  end

  // A new result sets ready between reads; a load in the end-of-read cycle is ignored and the clear wins.
  always_ff @(posedge mclk) begin
    if (int_rst) begin
      ready_n_reg <= 1'b1;
    end else if (result_load && (bit_cnt_reg == '0) && !sclk_d_reg) begin
      ready_n_reg <= 1'b0;
    end else if (rise && bit_cnt_reg == WORD_CNT - 5'd1) begin
      ready_n_reg <= 1'b1;
    end
  end

  assign pins.dout_o         = dout_reg;
  assign pins.dout_oe        = sel;
  assign pins.result_ready_n = ready_n_reg;
  // Direct inverted buffer of the input clock.
  assign pins.buffered_clock_output = !pins.master_clock_input;
  assign pins.buffered_clock_oe     = !clock_output_disable;
  assign rx_word  = rx_reg;
  assign rx_valid = rx_valid_reg;
endmodule : asp_dev
`default_nettype wire

// [verilog/asp_host.sv]
`timescale 1ns/1ps
`default_nettype none
module asp_host (
  // System.
  input  wire logic                       mclk,
  input  wire logic                       rst_b,
  // Pins.
  asp_if.host                             pins,
  // User side.
  input  wire logic                       start,
  input  wire logic [asp_pkg::WORD_W-1:0] tx_data,
  input  wire logic                       dev_reset,
  output logic                            busy,
  output logic      [asp_pkg::WORD_W-1:0] rd_data,
  output logic                            rd_valid,
  output logic                            ready_seen
);
  import asp_pkg::*;

  asp_state_t        state_reg;
  logic [7:0]        div_reg;
  logic [CNT_W-1:0]  cnt_reg;
  logic [WORD_W-1:0] tx_reg;
  logic [WORD_W-1:0] rx_reg;
  logic [1:0]        dout_sync_reg;
  logic [1:0]        rdy_sync_reg;
  logic              rd_valid_reg;
  logic              tick;

  assign tick = (div_reg == HALF_CNT - 8'd1);

  always_ff @(posedge mclk) begin
    dout_sync_reg <= {dout_sync_reg[0], pins.dout_o};
    rdy_sync_reg  <= {rdy_sync_reg[0], pins.result_ready_n};
  end

  always_ff @(posedge mclk) begin
    if (!rst_b || state_reg == ASP_IDLE || tick) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 8'd1;
    end
  end

  // Sample late in the high phase, well after the device's 2-cycle sync.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_reg <= ASP_IDLE;
      cnt_reg   <= '0;
      tx_reg    <= '0;
      rx_reg    <= '0;
    end else begin
      case (state_reg)
        ASP_IDLE: begin
          if (start) begin
            state_reg <= ASP_LOW;
            tx_reg    <= tx_data;
            cnt_reg   <= '0;
          end
        end
        ASP_LOW: begin
          if (tick) begin
            state_reg <= ASP_HIGH;
          end
        end
        ASP_HIGH: begin
          if (tick) begin
            rx_reg  <= {rx_reg[WORD_W-2:0], dout_sync_reg[1]};
            tx_reg  <= {tx_reg[WORD_W-2:0], 1'b0};
            cnt_reg <= cnt_reg + 5'd1;
            state_reg <= (cnt_reg == WORD_CNT - 5'd1) ? ASP_DONE : ASP_LOW;
          end
        end
        ASP_DONE: begin
          if (tick) begin
            state_reg <= ASP_IDLE;
          end
        end
        default: state_reg <= ASP_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= (state_reg == ASP_DONE) && tick;
    end
  end

  assign pins.sclk     = (state_reg == ASP_HIGH);
  assign pins.cs_n     = (state_reg == ASP_IDLE);
  assign pins.din      = tx_reg[WORD_W-1];
  // Internal oscillator use: clock input held at ground.
  assign pins.master_clock_input = 1'b0;
  assign pins.reset_n  = !dev_reset;
  assign busy          = (state_reg != ASP_IDLE);
  assign rd_data       = rx_reg;
  assign rd_valid      = rd_valid_reg;
  assign ready_seen    = !rdy_sync_reg[1];
endmodule : asp_host
`default_nettype wire

// [testbench/asp_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module asp_properties (
  // System.
  input wire logic mclk,
  input wire logic rst_b,
  // Link.
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic dout_o,
  input wire logic dout_oe,
  input wire logic result_ready_n,
  input wire logic master_clock_input,
  input wire logic buffered_clock_output,
  input wire logic buffered_clock_oe,
  input wire logic reset_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_dout_released_idle:
    assert property (cs_n [*4] |-> !dout_oe) else $error("dout driven");
  a_buffered_clock_output_inverted:
    assert property (buffered_clock_oe |->
      buffered_clock_output == !master_clock_input) else $error("buffered_clock_output");
  a_dout_holds_high:
    assert property (dout_oe && sclk && $past(sclk) |-> $stable(dout_o))
    else $error("dout moved in high phase");
  a_dout_moves_low:
    assert property (dout_oe && $past(dout_oe) && $changed(dout_o)
      |-> !sclk) else $error("dout moved with sclk high");
  a_ready_cleared_reset:
    assert property (!reset_n [*5] |-> result_ready_n)
    else $error("ready low in reset");
  a_clock_input_ground:
    assert property (!master_clock_input) else $error("clock input set");
  a_sclk_high_span:
    assert property ($rose(sclk) |-> sclk [*8] ##1 sclk ##1 sclk ##1 !sclk)
    else $error("sclk high phase");
  a_sclk_still_idle:
    assert property (cs_n |-> !sclk) else $error("sclk moves deselected");
endmodule : asp_properties
`default_nettype wire

// [testbench/adc_serial_port_pins_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_serial_port_pins_bench;
  import asp_pkg::*;
  logic              mclk = 1'b0;
  logic              rst_b = 1'b0;
  logic              start = 1'b0;
  logic              ld = 1'b0;
  logic              dis = 1'b0;
  logic              dev_reset = 1'b0;
  logic [WORD_W-1:0] tx = '0;
  logic [WORD_W-1:0] rdat = '0;
  logic [WORD_W-1:0] rx_word;
  logic [WORD_W-1:0] rd_data;
  logic              rx_valid;
  logic              busy;
  logic              rd_valid;
  logic              ready_seen;
  integer            seed = 32'h25F09957;
  int                failures = 0;
  int                cmp_count = 0;
  int                rx_pulses = 0;
  asp_if bus ();
  asp_dev asp_dev_inst (.mclk, .rst_b, .pins(bus.dev), .result_load(ld),
    .result_data(rdat), .clock_output_disable(dis), .rx_word, .rx_valid);
  asp_host asp_host_inst (.mclk, .rst_b, .pins(bus.host), .start,
    .tx_data(tx), .dev_reset, .busy, .rd_data, .rd_valid, .ready_seen);
  asp_properties asp_properties_inst (.mclk, .rst_b, .sclk(bus.sclk),
    .cs_n(bus.cs_n), .dout_o(bus.dout_o), .dout_oe(bus.dout_oe),
    .result_ready_n(bus.result_ready_n),
    .master_clock_input(bus.master_clock_input),
    .buffered_clock_output(bus.buffered_clock_output),
    .buffered_clock_oe(bus.buffered_clock_oe), .reset_n(bus.reset_n));
  always #5 mclk = ~mclk;
  // Counts received-word pulses so each read can expect exactly one.
  always @(posedge mclk) begin
    if (rx_valid === 1'b1) begin
      rx_pulses <= rx_pulses + 1;
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  task automatic chk16(input logic [WORD_W-1:0] e, input logic [WORD_W-1:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk16
  task automatic chk1(input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk1
  // Loads a result, then reads it while sending t.
  task automatic xfer(input logic [WORD_W-1:0] t, input logic [WORD_W-1:0] r);
    int n;
    int p;
    n = 0;
    p = rx_pulses;
    tx = t;
    rdat = r;
    ld = 1'b1;
    cyc(1);
    ld = 1'b0;
    cyc(6);
    chk1(1'b1, ready_seen);
    start = 1'b1;
    cyc(1);
    start = 1'b0;
    chk1(1'b1, busy);
    while (rd_valid !== 1'b1 && n < 600) begin
      cyc(1);
      n++;
    end
    if (n >= 600) begin
      failures++;
    end
    chk16(16'(p + 1), 16'(rx_pulses));
    chk16(r, rd_data);
    chk16(t, rx_word);
    cyc(6);
    chk1(1'b0, ready_seen);
  endtask : xfer
  task automatic print_verdict;
    $display("mismatches=%0d compares=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  initial begin
    cyc(3);
    rst_b = 1'b1;
    xfer(16'h8001, 16'hFFFF);
    xfer(16'h0000, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      dis = i[0];
      cyc(2);
      chk1(~dis, bus.buffered_clock_oe);
      xfer(16'($random(seed)), 16'($random(seed)));
    end
    ld = 1'b1;
    cyc(1);
    ld = 1'b0;
    dev_reset = 1'b1;
    cyc(8);
    dev_reset = 1'b0;
    cyc(6);
    chk1(1'b0, ready_seen);
    print_verdict();
  end
  initial begin
    #100000;
    failures++;
    print_verdict();
  end
endmodule : adc_serial_port_pins_bench
`default_nettype wire
